// ### logic/xc_params.svh
// constants of the sts/vt cross-connect
`ifndef XC_PARAMS_SVH
`define XC_PARAMS_SVH
`define XC_STS_PORTS   288
`define XC_STS_CONN    144
`define XC_VT_LSTS     24
`define XC_VT_PER_STS  28
`define XC_VT_PORTS    672
`define XC_VT_CONN     336
`define XC_VT_GROUPS   7
`define XC_VT_TRIBS    4
`define XC_IN_SLOTS    960
`define XC_OUT_SLOTS   624
`define XC_HS_CAP      48
`define XC_LS_CAP      12
`define XC_LS_BASE_A   0
`define XC_HS_BASE_A   48
`define XC_HS_BASE_B   144
`define XC_LS_BASE_B   240
`define XC_BUF_DEPTH   2
`define XC_ASI_GREEN   2'h2
`define XC_ASI_AMBER   2'h1
`endif

// ### logic/xc_pkg.sv
// types of the sts/vt cross-connect
package xc_pkg;
	// low-order tributary action
	typedef enum logic [1:0] {
		XC_VT_IDLE = 2'h0,
		XC_VT_PASS = 2'h1,
		XC_VT_DROP = 2'h2,
		XC_VT_MOVE = 2'h3
	} xc_vt_mode_t;
	// configuration sequencer, gray coded
	typedef enum logic {
		XC_CFG_IDLE  = 1'h0,
		XC_CFG_WRITE = 1'h1
	} xc_cfg_st_t;
	// one incoming timeslot word
	typedef struct packed {
		logic       sof;
		logic [9:0] idx;
		logic [7:0] data;
	} xc_in_t;
	// one outgoing timeslot word
	typedef struct packed {
		logic       sof;
		logic       vt;
		logic       drop;
		logic [9:0] idx;
		logic [7:0] data;
	} xc_out_t;
	// one low-order map entry
	typedef struct packed {
		xc_vt_mode_t mode;
		logic [9:0]  src;
	} xc_vt_ent_t;
	// one connection request
	typedef struct packed {
		logic        vt;
		logic [4:0]  dst_slot;
		logic [5:0]  dst_chan;
		logic [4:0]  src_slot;
		logic [5:0]  src_chan;
		logic [5:0]  len;
		logic [8:0]  vt_dst;
		logic [4:0]  vt_sts;
		logic [4:0]  vt_num;
		xc_vt_mode_t vt_mode;
	} xc_cfg_t;
endpackage

// ### logic/xc_cross_connect.sv
// time-division sts/vt cross-connect core
`timescale 1ns/100ps
`include "xc_params.svh"
module xc_cross_connect
	import xc_pkg::*;
(
	// clock and reset
	input  wire logic    clk,
	input  wire logic    rst_n,
	// incoming timeslot stream
	input  wire logic    in_valid,
	input  wire xc_in_t  in_word,
	// outgoing timeslot stream
	output logic         out_valid,
	input  wire logic    out_ready,
	output xc_out_t      out_word,
	// connection setup from controller
	input  wire logic    cfg_valid,
	output logic         cfg_ready,
	input  wire xc_cfg_t cfg,
	input  wire logic    cfg_commit,
	output logic         cfg_err,
	output logic         commit_pend,
	// card status
	input  wire logic    proc_ready,
	input  wire logic    card_active,
	output logic         fault_ind,
	output logic [1:0]   active_standby_indicator
);

	// all control state
	typedef struct packed {
		xc_cfg_st_t st;
		logic [5:0] wr_cnt;
		logic [8:0] wr_dst;
		logic [8:0] wr_src;
		logic       err;
		logic       pend;
		logic       in_bank;
		logic       seen_sof;
		logic       run;
		logic [9:0] out_idx;
		xc_out_t    buf0;
		xc_out_t    buf1;
		logic [1:0] cnt;
		logic       fault;
		logic [1:0] asi;
	} xc_state_t;

	xc_state_t  state_reg;  // registered state
	xc_state_t  state_next; // next state

	logic [7:0] dmem [2][`XC_IN_SLOTS];
	// sts maps, one source per output
	logic [8:0] sts_sh  [`XC_STS_PORTS];
	logic [8:0] sts_act [`XC_STS_PORTS];
	xc_vt_ent_t vt_sh  [`XC_VT_CONN];
	xc_vt_ent_t vt_act [`XC_VT_CONN];

	logic       sts_we; // sts shadow write
	logic [8:0] sts_wa; // its address
	logic [8:0] sts_wd; // its source
	logic       vt_we;  // vt shadow write
	logic [8:0] vt_wa;  // its address
	xc_vt_ent_t vt_wd;  // its entry
	logic       swap;   // copy shadow to active
	logic       push;   // word into buffer
	logic       pop;    // word out of buffer
	logic [9:0] dchk;   // dst check {ok,idx}
	logic [9:0] schk;   // src check {ok,idx}
	logic [10:0] vchk;  // vt check {ok,pos}
	logic       len_ok; // legal payload size
	xc_out_t    word;   // word being scheduled

	// slot/channel to matrix port, {ok,idx}
	function automatic logic [9:0] port_of(input logic [4:0] s, input logic [5:0] c,
		input logic [5:0] len);
		logic [8:0] b;
		logic [6:0] cap;
		b = 9'h0;
		cap = 7'h0;
		if (s >= 5'h1 && s <= 5'h4) begin
			b = 9'(`XC_LS_BASE_A + (s - 5'h1) * `XC_LS_CAP);
			cap = 7'(`XC_LS_CAP);
		end else if (s == 5'h5 || s == 5'h6) begin
			b = 9'(`XC_HS_BASE_A + (s - 5'h5) * `XC_HS_CAP);
			cap = 7'(`XC_HS_CAP);
		end else if (s == 5'hc || s == 5'hd) begin
			b = 9'(`XC_HS_BASE_B + (s - 5'hc) * `XC_HS_CAP);
			cap = 7'(`XC_HS_CAP);
		end else if (s >= 5'he && s <= 5'h11) begin
			b = 9'(`XC_LS_BASE_B + (s - 5'he) * `XC_LS_CAP);
			cap = 7'(`XC_LS_CAP);
		end
		return {(cap != 7'h0) && (7'(c) + 7'(len) <= cap), 9'(b + 9'(c))};
	endfunction

	// vt number to tributary position, {ok,pos}
	function automatic logic [10:0] vt_pos(input logic [4:0] sts, input logic [4:0] num);
		logic [4:0] n1;
		n1 = num - 5'h1;
		return {(sts < 5'(`XC_VT_LSTS)) && (num >= 5'h1) && (num <= 5'(`XC_VT_PER_STS)),
			10'(sts * `XC_VT_PER_STS + (n1 % `XC_VT_GROUPS) * `XC_VT_TRIBS
			+ n1 / `XC_VT_GROUPS)};
	endfunction

	// outputs straight from state
	assign cfg_ready = (state_reg.st == XC_CFG_IDLE);
	assign cfg_err = state_reg.err;
	assign commit_pend = state_reg.pend;
	assign fault_ind = state_reg.fault;
	assign active_standby_indicator = state_reg.asi;
	assign out_valid = (state_reg.cnt != 2'h0);
	assign out_word = state_reg.buf0;

	// request checks
	assign dchk = port_of(cfg.dst_slot, cfg.dst_chan, cfg.len);
	assign schk = port_of(cfg.src_slot, cfg.src_chan, cfg.len);
	assign vchk = vt_pos(cfg.vt_sts, cfg.vt_num);
	assign len_ok = (cfg.len == 6'h1) || (cfg.len == 6'h3) || (cfg.len == 6'h6)
		|| (cfg.len == 6'hc) || (cfg.len == 6'h30);

	// handshake on the buffer
	assign pop = out_valid && out_ready;
	assign push = state_reg.run && (state_reg.cnt != 2'(`XC_BUF_DEPTH));
	// swap after the last slot of a frame
	assign swap = push && state_reg.pend
		&& (state_reg.out_idx == 10'(`XC_OUT_SLOTS - 1));

	// schedule the current output slot
	always_comb begin
		xc_vt_ent_t e;
		logic [9:0] vi;
		e = vt_act[0];
		vi = 10'h0;
		word = '0;
		word.sof = (state_reg.out_idx == 10'h0);
		word.idx = state_reg.out_idx;
		if (state_reg.out_idx < 10'(`XC_STS_PORTS)) begin
			word.data = dmem[~state_reg.in_bank][sts_act[state_reg.out_idx[8:0]]];
		end else begin
			vi = state_reg.out_idx - 10'(`XC_STS_PORTS);
			e = vt_act[vi[8:0]];
			word.vt = 1'h1;
			word.drop = (e.mode == XC_VT_DROP);
			if (e.mode != XC_VT_IDLE) begin
				word.data = dmem[~state_reg.in_bank][10'(`XC_STS_PORTS) + e.src];
			end
		end
	end

	// next-state logic
	always_comb begin
		state_next = state_reg;
		state_next.err = 1'h0;
		sts_we = 1'h0;
		sts_wa = state_reg.wr_dst;
		sts_wd = state_reg.wr_src;
		vt_we = 1'h0;
		vt_wa = cfg.vt_dst;
		vt_wd = '{mode: cfg.vt_mode, src: vchk[9:0]};
		state_next.fault = !proc_ready;
		state_next.asi = card_active ? `XC_ASI_GREEN : `XC_ASI_AMBER;
		// setup sequencer
		case (state_reg.st)
			XC_CFG_IDLE: begin
				if (cfg_valid) begin
					if (cfg.vt) begin
						if (vchk[10] && cfg.vt_dst < 9'(`XC_VT_CONN)) begin
							vt_we = 1'h1;
						end else begin
							state_next.err = 1'h1;
						end
					end else if (dchk[9] && schk[9] && len_ok) begin
						state_next.st = XC_CFG_WRITE;
						state_next.wr_cnt = cfg.len;
						state_next.wr_dst = dchk[8:0];
						state_next.wr_src = schk[8:0];
					end else begin
						state_next.err = 1'h1;
					end
				end
			end
			XC_CFG_WRITE: begin
				sts_we = 1'h1;
				state_next.wr_dst = state_reg.wr_dst + 9'h1;
				state_next.wr_src = state_reg.wr_src + 9'h1;
				state_next.wr_cnt = state_reg.wr_cnt - 6'h1;
				if (state_reg.wr_cnt == 6'h1) begin
					state_next.st = XC_CFG_IDLE;
				end
			end
			default: begin
				state_next.st = XC_CFG_IDLE;
			end
		endcase
		// commit arms, set wins over clear
		if (swap) begin
			state_next.pend = 1'h0;
		end
		if (cfg_commit) begin
			state_next.pend = 1'h1;
		end
		// input frame banks flip on frame start
		if (in_valid && in_word.sof) begin
			state_next.in_bank = !state_reg.in_bank;
			state_next.seen_sof = 1'h1;
			// one whole frame stored: start output
			if (state_reg.seen_sof) begin
				state_next.run = 1'h1;
			end
		end
		// output slot counter
		if (push) begin
			if (state_reg.out_idx == 10'(`XC_OUT_SLOTS - 1)) begin
				state_next.out_idx = 10'h0;
			end else begin
				state_next.out_idx = state_reg.out_idx + 10'h1;
			end
		end
		// two-entry buffer
		if (push && pop) begin
			if (state_reg.cnt == 2'h1) begin
				state_next.buf0 = word;
			end else begin
				state_next.buf0 = state_reg.buf1;
				state_next.buf1 = word;
			end
		end else if (push) begin
			if (state_reg.cnt == 2'h0) begin
				state_next.buf0 = word;
			end else begin
				state_next.buf1 = word;
			end
			state_next.cnt = state_reg.cnt + 2'h1;
		end else if (pop) begin
			state_next.buf0 = state_reg.buf1;
			state_next.cnt = state_reg.cnt - 2'h1;
		end
	end

	// register the state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= '0;
			state_reg.fault <= 1'h1;
			state_reg.asi <= `XC_ASI_AMBER;
		end else begin
			state_reg <= state_next;
		end
	end

	// frame data store
	always_ff @(posedge clk) begin
		if (in_valid && in_word.idx < 10'(`XC_IN_SLOTS)) begin
			dmem[in_word.sof ? !state_reg.in_bank : state_reg.in_bank][in_word.idx] <= in_word.data;
		end
	end

	// map stores, one source entry per output
	always_ff @(posedge clk) begin
		if (sts_we) begin
			sts_sh[sts_wa] <= sts_wd;
		end
		if (vt_we) begin
			vt_sh[vt_wa] <= vt_wd;
		end
		if (!rst_n) begin
			// straight-through, vts idle
			for (int i = 0; i < `XC_STS_PORTS; i++) begin
				sts_act[i] <= 9'(i);
			end
			for (int i = 0; i < `XC_VT_CONN; i++) begin
				vt_act[i] <= '0;
			end
		end else if (swap) begin
			for (int i = 0; i < `XC_STS_PORTS; i++) begin
				sts_act[i] <= sts_sh[i];
			end
			for (int i = 0; i < `XC_VT_CONN; i++) begin
				vt_act[i] <= vt_sh[i];
			end
		end
	end

	// request sequences
	sequence sts_take_s;
		cfg_valid && cfg_ready && !cfg.vt && dchk[9] && schk[9] && len_ok;
	endsequence
	sequence busy3_s;
		!cfg_ready [*3] ##1 cfg_ready;
	endsequence

	fault_on_a: assert property (@(posedge clk) disable iff (!rst_n)
		!proc_ready |=> fault_ind)
		else $error("fault not shown with processor not ready");
	fault_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		proc_ready ##1 proc_ready |=> !fault_ind)
		else $error("fault shown with processor ready");
	act_led_a: assert property (@(posedge clk) disable iff (!rst_n)
		card_active |=> active_standby_indicator == `XC_ASI_GREEN)
		else $error("active indication wrong");
	stby_led_a: assert property (@(posedge clk) disable iff (!rst_n)
		!card_active |=> active_standby_indicator == `XC_ASI_AMBER)
		else $error("standby indication wrong");
	concat_len_a: assert property (@(posedge clk) disable iff (!rst_n)
		sts_take_s ##0 (cfg.len == 6'h3) |=> busy3_s)
		else $error("sts-3c not written as three slots");
	bad_slot_a: assert property (@(posedge clk) disable iff (!rst_n)
		cfg_valid && cfg_ready && !cfg.vt && (cfg.dst_slot == 5'h7) |=> cfg_err)
		else $error("request to slot without capacity accepted");
	vt_num_a: assert property (@(posedge clk) disable iff (!rst_n)
		cfg_valid && cfg_ready && cfg.vt && (cfg.vt_sts == 5'h0) && (cfg.vt_num == 5'h1c)
		&& (cfg.vt_dst == 9'h0) |=> vt_sh[0].src == 10'h1b)
		else $error("vt28 not group7/vt4");
	swap_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
		swap && !cfg_commit |=> !commit_pend ##1 1'b1)
		else $error("pending setup not applied at frame end");
	slot_rng_a: assert property (@(posedge clk) disable iff (!rst_n)
		push && word.sof |-> word.idx == 10'h0 && !word.vt)
		else $error("frame not starting at sts slot 0");
	hold_out_a: assert property (@(posedge clk) disable iff (!rst_n)
		out_valid && !out_ready |=> out_valid && $stable(out_word))
		else $error("stalled word lost");

endmodule

// ### testbench/xc_line_model.sv
// line-card traffic source and sink facing the cross-connect
`timescale 1ns/100ps
module xc_line_model
	import xc_pkg::*;
(
	// clock and reset
	input  wire logic    clk,
	input  wire logic    rst_n,
	// bench controls
	input  wire logic    en,
	input  wire logic    stall,
	// source side
	output logic         in_valid,
	output xc_in_t       in_word,
	// sink side
	input  wire logic    out_valid,
	output logic         out_ready,
	input  wire xc_out_t out_word
);
	logic [9:0] pos_reg;      // next slot to send
	logic [1:0] ph_reg;       // stall phase
	int         frames;       // frame starts seen
	xc_out_t    seen [0:623]; // last word per output slot
	// quiet lines at time zero
	initial begin
		in_valid = 1'b0;
		in_word = '0;
		out_ready = 1'b0;
	end
	// source: 960 slots back to back, data is the slot's low byte
	always @(posedge clk) begin
		if (!rst_n || !en) begin
			pos_reg <= 10'h000;
			in_valid <= 1'b0;
			in_word <= ~in_word;
		end else begin
			in_valid <= 1'b1;
			in_word <= '{sof: pos_reg == 10'h000, idx: pos_reg, data: pos_reg[7:0]};
			pos_reg <= (pos_reg == 10'h3bf) ? 10'h000 : pos_reg + 10'h001;
		end
	end
	// sink: stalls one cycle in four, keeps last word per slot
	always @(posedge clk) begin
		ph_reg <= rst_n ? ph_reg + 2'h1 : 2'h0;
		out_ready <= !(stall && ph_reg == 2'h0);
		if (!rst_n) begin
			frames <= 0;
		end else if (out_valid && out_ready && out_word.idx < 10'd624) begin
			seen[out_word.idx] <= out_word;
			frames <= frames + int'(out_word.sof);
		end
	end
endmodule

// ### testbench/xc_cross_connect_tb.sv
// self-checking bench of the sts/vt cross-connect
`timescale 1ns/100ps
module xc_cross_connect_tb import xc_pkg::*;;
	logic       clk, rst_n, en, stall, in_valid, out_valid, out_ready;
	logic       cfg_valid, cfg_ready, cfg_commit, cfg_err, commit_pend;
	logic       proc_ready, card_active, fault_ind;
	logic [1:0] active_standby_indicator;
	xc_in_t     in_word;
	xc_out_t    out_word;
	xc_cfg_t    cfg;
	int         fail_count = 0, samples_checked = 0, cyc = 0;
	// sts requests: dst slot, dst chan, src slot, src chan, length
	int st [7][5] = '{'{1,0,5,0,1}, '{1,1,5,0,1}, '{2,0,13,47,1}, '{2,1,14,0,3},
		'{3,0,4,0,6}, '{4,0,17,0,12}, '{6,0,12,0,48}};
	// vt requests: dst, logical sts, vt number, mode
	int vt [5][4] = '{'{0,0,28,1}, '{1,1,1,2}, '{2,2,5,3}, '{3,23,14,0}, '{335,3,7,1}};
	xc_cross_connect dut (.clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_word(in_word),
		.out_valid(out_valid), .out_ready(out_ready), .out_word(out_word), .cfg_valid(cfg_valid),
		.cfg_ready(cfg_ready), .cfg(cfg), .cfg_commit(cfg_commit), .cfg_err(cfg_err),
		.commit_pend(commit_pend), .proc_ready(proc_ready), .card_active(card_active),
		.fault_ind(fault_ind), .active_standby_indicator(active_standby_indicator));
	xc_line_model m (.clk(clk), .rst_n(rst_n), .en(en), .stall(stall), .in_valid(in_valid),
		.in_word(in_word), .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word));
	// clock at 8 ns
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			conclude();
		end
	end
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic chk_slot(input int i, input logic [7:0] d, input logic dr);
		chk({m.seen[i].idx, m.seen[i].vt, m.seen[i].drop, m.seen[i].data}, {i[9:0], i >= 288, dr, d});
	endtask
	// line port of a slot and channel
	function automatic int port(input int s, input int c);
		if (s < 5) return (s - 1) * 12 + c;
		if (s < 12) return 48 + (s - 5) * 48 + c;
		if (s < 14) return 144 + (s - 12) * 48 + c;
		return 240 + (s - 14) * 12 + c;
	endfunction
	// input position of vt n: group-major inside its sts
	function automatic int vt_idx(input int s, input int n);
		return 288 + s * 28 + ((n - 1) % 7) * 4 + (n - 1) / 7;
	endfunction
	function automatic xc_cfg_t sreq(input int ds, input int dc, input int ss, input int sc, input int ln);
		xc_cfg_t c;
		c = '0;
		c.dst_slot = 5'(ds);
		c.dst_chan = 6'(dc);
		c.src_slot = 5'(ss);
		c.src_chan = 6'(sc);
		c.len = 6'(ln);
		return c;
	endfunction
	function automatic xc_cfg_t vreq(input int d, input int s, input int n, input xc_vt_mode_t md);
		xc_cfg_t c;
		c = '0;
		c.vt = 1'b1;
		c.vt_dst = 9'(d);
		c.vt_sts = 5'(s);
		c.vt_num = 5'(n);
		c.vt_mode = md;
		return c;
	endfunction
	task automatic send(input xc_cfg_t c, input logic err);
		int n;
		n = 0;
		@(posedge clk);
		cfg_valid <= 1'b1;
		cfg <= c;
		@(posedge clk);
		cfg_valid <= 1'b0;
		cfg <= ~c;
		#1;
		chk(cfg_err, err);
		while (cfg_ready === 1'b0 && n < 60) begin
			n++;
			@(posedge clk);
			#1;
		end
		chk(20'(n), 20'((!err && !c.vt) ? int'(c.len) : 0));
	endtask
	task automatic wait_frames(input int n);
		int f0;
		f0 = m.frames;
		repeat (2000 * n) begin
			@(posedge clk);
			if (m.frames >= f0 + n) break;
		end
		chk(m.frames >= f0 + n, 1'b1);
	endtask
	task automatic t_status();
		chk({out_valid, cfg_ready, cfg_err, commit_pend, fault_ind, active_standby_indicator}, 7'b0100101);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			proc_ready <= k[0];
			card_active <= k[1];
			@(posedge clk);
			#1;
			chk({fault_ind, active_standby_indicator}, {~k[0], k[1] ? 2'h2 : 2'h1});
		end
		$display("test status done");
	endtask
	task automatic t_straight();
		wait_frames(3);
		chk_slot(5, 8'h05, 1'b0);
		chk_slot(287, 8'h1f, 1'b0);
		chk_slot(288, 8'h00, 1'b0);
		$display("test straight done");
	endtask
	task automatic t_refuse();
		send(sreq(7, 0, 1, 0, 1), 1'b1);
		send(sreq(1, 11, 5, 0, 3), 1'b1);
		send(sreq(1, 0, 5, 0, 48), 1'b1);
		send(sreq(5, 0, 6, 0, 5), 1'b1);
		send(vreq(0, 24, 1, XC_VT_PASS), 1'b1);
		send(vreq(0, 0, 0, XC_VT_PASS), 1'b1);
		send(vreq(0, 0, 29, XC_VT_PASS), 1'b1);
		send(vreq(336, 0, 1, XC_VT_PASS), 1'b1);
		$display("test refuse done");
	endtask
	task automatic t_map();
		// shadow maps are not reset: write every entry before the first commit
		for (int s = 1; s < 18; s++)
			if (s < 7 || s > 11) send(sreq(s, 0, s, 0, (s % 7 == 5 || s % 7 == 6) ? 48 : 12), 1'b0);
		for (int i = 0; i < 336; i++) send(vreq(i, 0, 1, XC_VT_IDLE), 1'b0);
		foreach (st[r]) send(sreq(st[r][0], st[r][1], st[r][2], st[r][3], st[r][4]), 1'b0);
		foreach (vt[r]) send(vreq(vt[r][0], vt[r][1], vt[r][2], xc_vt_mode_t'(vt[r][3])), 1'b0);
		wait_frames(1);
		chk_slot(0, 8'h00, 1'b0);
		$display("test map load done");
	endtask
	task automatic t_commit();
		int n;
		n = 0;
		@(posedge clk);
		cfg_commit <= 1'b1;
		@(posedge clk);
		cfg_commit <= 1'b0;
		#1;
		chk(commit_pend, 1'b1);
		while (commit_pend === 1'b1 && n < 3000) begin
			n++;
			@(posedge clk);
			#1;
		end
		chk(commit_pend, 1'b0);
		wait_frames(2);
		foreach (st[r]) for (int k = 0; k < st[r][4]; k++)
			chk_slot(port(st[r][0], st[r][1]) + k, 8'(port(st[r][2], st[r][3]) + k), 1'b0);
		foreach (vt[r])
			chk_slot(288 + vt[r][0], vt[r][3] == 0 ? 8'h00 : 8'(vt_idx(vt[r][1], vt[r][2])), vt[r][3] == 2);
		chk_slot(2, 8'h02, 1'b0);
		chk_slot(292, 8'h00, 1'b0);
		$display("test commit done");
	endtask
	// reset, then the scenarios in turn
	initial begin
		rst_n = 1'b0;
		en = 1'b0;
		stall = 1'b1;
		cfg_valid = 1'b0;
		cfg = '0;
		cfg_commit = 1'b0;
		proc_ready = 1'b0;
		card_active = 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		en <= 1'b1;
		@(posedge clk);
		#1;
		t_status();
		t_straight();
		t_refuse();
		t_map();
		t_commit();
		conclude();
	end
endmodule
